// *** hw/dpram_host.sv ***
// host controller driving both ports of an asynchronous 2k x 8 dual-port ram
// assumes ram pins are sampled synchronously; ram busy is open-drain on the board
//
// Overview of operation
// - hold rw high while address changes
// - never drive data while ram outputs
// - oe low stretches write pulse
// - hold write past busy release
// - slave busy input low before write
`default_nettype none
module dpram_host (
	input  wire logic                                clk,
	input  wire logic                                rst_b,
	input  wire logic                                en,
	input  wire dpram_host_pkg::hostReq_s            lReq,
	input  wire logic                                lReqValid,
	output logic                                     lReqReady,
	output logic [dpram_host_pkg::DATA_W-1:0]        lRspData,
	output logic                                     lRspValid,
	output logic                                     lRspBusy,
	input  wire dpram_host_pkg::hostReq_s            rReq,
	input  wire logic                                rReqValid,
	output logic                                     rReqReady,
	output logic [dpram_host_pkg::DATA_W-1:0]        rRspData,
	output logic                                     rRspValid,
	output logic                                     rRspBusy,
	output dpram_host_pkg::ramPins_s                 lPins,
	output dpram_host_pkg::ramPins_s                 rPins,
	input  wire logic [dpram_host_pkg::DATA_W-1:0]   lDataIn,
	input  wire logic [dpram_host_pkg::DATA_W-1:0]   rDataIn,
	input  wire logic                                lBusyIn,
	input  wire logic                                rBusyIn,
	input  wire logic                                slaveMode,
	output logic                                     lBusyOut,
	output logic                                     rBusyOut,
	output logic                                     lBusyOe,
	output logic                                     rBusyOe
);
	logic lReady, rReady;

	// in slave mode the host itself drives ram busy pins as write inhibits
	// from the other port's ongoing access; in master mode it only listens
	wire lActive = !lPins.ceB;
	wire rActive = !rPins.ceB;
	wire match   = lActive && rActive && (lPins.addr == rPins.addr);
	logic lOwns_r, rOwns_r;
	logic lWas_r, rWas_r; // chip select seen low one cycle earlier

	// ownership latched on first overlap so only one side is ever inhibited
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lOwns_r  <= 1'b0;
			rOwns_r  <= 1'b0;
			lWas_r   <= 1'b0;
			rWas_r   <= 1'b0;
			lBusyOut <= 1'b1;
			rBusyOut <= 1'b1;
			lBusyOe  <= 1'b0;
			rBusyOe  <= 1'b0;
			lReqReady <= 1'b0;
			rReqReady <= 1'b0;
		end else if (en) begin
			if (!match) begin
				lOwns_r <= 1'b0;
				rOwns_r <= 1'b0;
			end else if (!lOwns_r && !rOwns_r) begin
				// the port already selected keeps the location; a tie goes left
				if (rWas_r && !lWas_r)
					rOwns_r <= 1'b1;
				else
					lOwns_r <= 1'b1;
			end
			lWas_r <= lActive;
			rWas_r <= rActive;
			lBusyOut <= 1'b0;
			rBusyOut <= 1'b0;
			lBusyOe  <= slaveMode && match && rOwns_r;
			rBusyOe  <= slaveMode && match && lOwns_r;
			lReqReady <= lReady;
			rReqReady <= rReady;
		end
	end

	// busy seen by each sequencer: pin low when ram or host inhibits
	wire lBusyEff = lBusyIn && !(slaveMode && match && rOwns_r);
	wire rBusyEff = rBusyIn && !(slaveMode && match && lOwns_r);

	dpram_port_ctrl uLeft (
		.clk         (clk),
		.rst_b       (rst_b),
		.en          (en),
		.req         (lReq),
		.reqValid    (lReqValid),
		.reqReady    (lReady),
		.busyB       (lBusyEff),
		.rdata       (lDataIn),
		.pins        (lPins),
		.rspData     (lRspData),
		.rspValid    (lRspValid),
		.rspBusySeen (lRspBusy)
	);
	dpram_port_ctrl uRight (
		.clk         (clk),
		.rst_b       (rst_b),
		.en          (en),
		.req         (rReq),
		.reqValid    (rReqValid),
		.reqReady    (rReady),
		.busyB       (rBusyEff),
		.rdata       (rDataIn),
		.pins        (rPins),
		.rspData     (rRspData),
		.rspValid    (rRspValid),
		.rspBusySeen (rRspBusy)
	);
endmodule
`default_nettype wire

// *** hw/dpram_host_pkg.sv ***
// package for the dual-port ram host controller: timing counts, pin bundles, states
// assumes a 40 MHz clock; all ram pins are treated as synchronous to it
`default_nettype none
package dpram_host_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int ADDR_W        = 11;
	localparam int DATA_W        = 8;
	// write timing, fastest grade figures in ns
	localparam int WP_NS      = 15;  // least write pulse
	localparam int WZ_NS      = 10;  // output turn-off after write enable
	localparam int DW_NS      = 10;  // data setup to end of write
	localparam int WH_NS      = 12;  // write hold after busy releases
	localparam int BAA_NS     = 20;  // busy access from address or enable
	localparam int WDD_NS     = 50;  // port-to-port write pulse to data
	localparam int DDD_NS     = 35;  // write data to read data
	localparam int AS_NS      = 0;   // address setup before write
	// least times round up, never below one cycle
	function automatic int ceilCyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int WP_CYC  = ceilCyc((WP_NS > WZ_NS + DW_NS) ? WP_NS : WZ_NS + DW_NS);
	localparam int WH_CYC  = ceilCyc(WH_NS);
	localparam int BAA_CYC = ceilCyc(BAA_NS);
	localparam int RD_CYC  = ceilCyc((WDD_NS > DDD_NS) ? WDD_NS : DDD_NS);
	localparam int AS_CYC  = ceilCyc(AS_NS);
	localparam logic [3:0] CNT_ZERO = 4'h0;
	// pins toward one ram port
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              ceB;
		logic              rwB;
		logic              oeB;
		logic [DATA_W-1:0] dout;
		logic              dOe;
	} ramPins_s;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              write;
	} hostReq_s;
	typedef enum logic [5:0] {
		IDLE  = 6'h01,
		SETUP = 6'h02,
		WAITB = 6'h04,
		PULSE = 6'h08,
		HOLD  = 6'h10,
		DONE  = 6'h20
	} portState_e;
endpackage
`default_nettype wire

// *** hw/dpram_port_ctrl.sv ***
// one ram-port host sequencer: runs one read or write per request
// assumes busyB and rdata are synchronous to clk; ram side is the dual-port part
`default_nettype none
module dpram_port_ctrl (
	input  wire logic                         clk,
	input  wire logic                         rst_b,
	input  wire logic                         en,
	input  wire dpram_host_pkg::hostReq_s     req,
	input  wire logic                         reqValid,
	output logic                              reqReady,
	input  wire logic                         busyB,
	input  wire logic [dpram_host_pkg::DATA_W-1:0] rdata,
	output dpram_host_pkg::ramPins_s          pins,
	output logic [dpram_host_pkg::DATA_W-1:0] rspData,
	output logic                              rspValid,
	output logic                              rspBusySeen
);
	dpram_host_pkg::portState_e state_r, state_nxt;
	dpram_host_pkg::hostReq_s   req_r;
	logic [3:0]                 cnt_r, cnt_nxt;
	logic                       busySeen_r;
	wire                        cntDone = (cnt_r == dpram_host_pkg::CNT_ZERO);
	wire                        accept  = (state_r == dpram_host_pkg::IDLE) && reqValid;

	// sequence: setup, wait out busy access, pulse, hold past busy release
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cntDone ? cnt_r : cnt_r - 4'h1;
		case (state_r)
			dpram_host_pkg::IDLE: if (reqValid) begin
				state_nxt = dpram_host_pkg::SETUP;
				cnt_nxt   = 4'(dpram_host_pkg::AS_CYC);
			end
			dpram_host_pkg::SETUP: if (cntDone) begin
				// busy may only be trusted after its access delay
				state_nxt = dpram_host_pkg::WAITB;
				cnt_nxt   = 4'(dpram_host_pkg::BAA_CYC);
			end
			dpram_host_pkg::WAITB: if (cntDone) begin
				state_nxt = dpram_host_pkg::PULSE;
				cnt_nxt   = 4'(req_r.write ? dpram_host_pkg::WP_CYC : dpram_host_pkg::RD_CYC);
			end
			dpram_host_pkg::PULSE: if (cntDone && busyB) begin
				state_nxt = busySeen_r ? dpram_host_pkg::HOLD : dpram_host_pkg::DONE;
				cnt_nxt   = 4'(dpram_host_pkg::WH_CYC);
			end
			dpram_host_pkg::HOLD: if (cntDone) begin
				state_nxt = dpram_host_pkg::DONE;
			end
			dpram_host_pkg::DONE: state_nxt = dpram_host_pkg::IDLE;
			default: state_nxt = dpram_host_pkg::IDLE;
		endcase
	end

	// pin drive: rw/ce high outside the request so address moves safely
	wire inAcc   = (state_r != dpram_host_pkg::IDLE) && (state_r != dpram_host_pkg::DONE);
	wire strobe  = (state_r == dpram_host_pkg::PULSE) || (state_r == dpram_host_pkg::HOLD);
	wire wrPulse = strobe && req_r.write;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r    <= dpram_host_pkg::IDLE;
			cnt_r      <= dpram_host_pkg::CNT_ZERO;
			req_r      <= '0;
			busySeen_r <= 1'b0;
			pins       <= '{addr: '0, ceB: 1'b1, rwB: 1'b1, oeB: 1'b1, dout: '0, dOe: 1'b0};
			rspData    <= '0;
			rspValid   <= 1'b0;
			rspBusySeen<= 1'b0;
		end else if (en) begin
			state_r  <= state_nxt;
			cnt_r    <= cnt_nxt;
			if (accept) begin
				req_r      <= req;
				busySeen_r <= 1'b0;
			end else if (strobe && !busyB) begin
				busySeen_r <= 1'b1;
			end
			if (accept)
				pins.addr <= req.addr;
			pins.ceB <= !(inAcc || accept);
			pins.rwB <= !wrPulse;
			// output enable high during writes keeps the ram off the data bus
			pins.oeB <= !(inAcc && !req_r.write);
			pins.dout <= req_r.wdata;
			pins.dOe  <= wrPulse;
			// one pulse on entering done, whether or not a hold came first
			rspValid  <= (state_nxt == dpram_host_pkg::DONE) && (state_r != dpram_host_pkg::DONE);
			if (state_r == dpram_host_pkg::PULSE && cntDone && busyB && !req_r.write)
				rspData <= rdata;
			rspBusySeen <= busySeen_r || (strobe && !busyB);
		end
	end
	assign reqReady = (state_r == dpram_host_pkg::IDLE);
endmodule
`default_nettype wire

// *** verification/dpram_host_assertions.sv ***
// checker: pin-level properties of the dual-port ram host
// assumes it is bound onto dpram_host, one clock domain
`default_nettype none
module dpram_host_checker (
	input wire logic                     clk,
	input wire logic                     rst_b,
	input wire logic                     slaveMode,
	input wire logic                     lBusyIn,
	input wire logic                     lBusyOe,
	input wire logic                     rBusyOe,
	input wire dpram_host_pkg::ramPins_s lPins,
	input wire dpram_host_pkg::ramPins_s rPins
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// strobe rules on the left pins, one on the right for symmetry
	addr_hold_a: assert property (!$stable(lPins.addr) |-> lPins.rwB && $past(lPins.rwB))
		else $error("address moved while strobe low");
	write_ce_a: assert property (!lPins.rwB |-> !lPins.ceB)
		else $error("write strobe without chip select");
	no_fight_a: assert property (lPins.dOe |-> lPins.oeB && !lPins.rwB)
		else $error("host drives data while ram may drive");
	right_fight_a: assert property (rPins.dOe |-> rPins.oeB)
		else $error("right host drives data while ram may drive");
	// a blocked write must outlast the busy release
	hold_busy_a: assert property ($rose(lBusyIn) && !lPins.rwB |=> !lPins.rwB)
		else $error("write dropped at busy release");
	read_wait_a: assert property ($fell(lPins.oeB) |-> !lPins.oeB [*2])
		else $error("read window too short");
	one_busy_a: assert property (!(lBusyOe && rBusyOe))
		else $error("busy driven on both sides");
	busy_early_a: assert property (slaveMode && $rose(rBusyOe) |-> rPins.rwB)
		else $error("slave busy raised after write began");
	cover property (slaveMode && rBusyOe);
	cover property (slaveMode && lBusyOe);
	cover property ($rose(lBusyIn) && !lPins.rwB);
	cover property (!lPins.oeB && !rPins.rwB);
endmodule
bind dpram_host dpram_host_checker i_chk (.clk, .rst_b, .slaveMode, .lBusyIn, .lBusyOe,
	.rBusyOe, .lPins, .rPins);
`default_nettype wire

// *** verification/dpram_model.sv ***
// behavioural dual-port ram with busy arbitration, master or slave mode
// assumes the host registers its pins on clk; busy pins are pulled up
`default_nettype none
module dpram_model (
	input  wire logic                     clk,
	input  wire logic                     master,
	input  wire dpram_host_pkg::ramPins_s lP,
	input  wire dpram_host_pkg::ramPins_s rP,
	input  wire logic                     lPull,
	input  wire logic                     rPull,
	output logic [7:0]                    lQ,
	output logic [7:0]                    rQ,
	output logic                          lBusy,
	output logic                          rBusy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [2048];
	logic [7:0] junk = 8'h5a;
	logic       lOn_r = 1'b0;
	logic       rOn_r = 1'b0;
	logic [1:0] win_r = 2'h0;
	wire match = !lP.ceB && !rP.ceB && lP.addr == rP.addr;
	// port already on the location wins; a tie goes left
	wire lLose = master && match && (win_r == 2'h2 || (win_r == 2'h0 && rOn_r && !lOn_r));
	wire rLose = master && match && !lLose;
	assign lBusy = !(lLose || lPull);
	assign rBusy = !(rLose || rPull);
	// drive only on a read; a released bus shows a moving pattern
	assign lQ = (!lP.ceB && !lP.oeB && lP.rwB) ? mem[lP.addr] : junk;
	assign rQ = (!rP.ceB && !rP.oeB && rP.rwB) ? mem[rP.addr] : junk;
	// arbitration memory and gated writes
	always @(posedge clk) begin
		junk <= ~junk + 8'h01;
		lOn_r <= !lP.ceB;
		rOn_r <= !rP.ceB;
		win_r <= !match ? 2'h0 : (win_r != 2'h0) ? win_r : lLose ? 2'h2 : 2'h1;
		if (!lP.ceB && !lP.rwB && lBusy && !lLose) mem[lP.addr] <= lP.dout;
		if (!rP.ceB && !rP.rwB && rBusy && !rLose) mem[rP.addr] <= rP.dout;
	end
endmodule
`default_nettype wire

// *** verification/tb_dual_port_ram_busy_arbitration.sv ***
// self-checking bench for the dual-port ram host controller
// assumes dpram_model stands on both ram ports
`default_nettype none
module tb_dual_port_ram_busy_arbitration;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic slaveMode = 1'b0;
	logic lV = 1'b0;
	logic rV = 1'b0;
	dpram_host_pkg::hostReq_s lReq = '0;
	dpram_host_pkg::hostReq_s rReq = '0;
	dpram_host_pkg::ramPins_s lPins, rPins;
	logic [7:0] lQ, rQ, lD, rD;
	logic lRv, rRv, lRb, rRb, lBi, rBi, lBo, rBo;
	logic lRdy, rRdy, lBso, rBso;
	int errors = 0;
	int checked = 0;
	always #12.5 clk = ~clk;
	dpram_host i_dut (.clk, .rst_b, .en(1'b1), .lReq, .lReqValid(lV), .lReqReady(lRdy),
		.lRspData(lD), .lRspValid(lRv), .lRspBusy(lRb), .rReq, .rReqValid(rV),
		.rReqReady(rRdy), .rRspData(rD), .rRspValid(rRv), .rRspBusy(rRb), .lPins, .rPins,
		.lDataIn(lQ), .rDataIn(rQ), .lBusyIn(lBi), .rBusyIn(rBi), .slaveMode,
		.lBusyOut(lBso), .rBusyOut(rBso), .lBusyOe(lBo), .rBusyOe(rBo));
	dpram_model i_ram (.clk, .master(!slaveMode), .lP(lPins), .rP(rPins), .lPull(lBo),
		.rPull(rBo), .lQ, .rQ, .lBusy(lBi), .rBusy(rBi));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one access; valid held until the sequencer leaves idle
	task automatic acc(input bit s, input bit w, input logic [10:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic b);
		int n;
		n = 0;
		@(posedge clk);
		if (s) rReq <= '{a, d, w};
		else lReq <= '{a, d, w};
		if (s) rV <= 1'b1;
		else lV <= 1'b1;
		do @(negedge clk); while ((s ? rPins.ceB : lPins.ceB) !== 1'b0 && n++ < 99);
		@(posedge clk);
		if (s) rV <= 1'b0;
		else lV <= 1'b0;
		do @(negedge clk); while ((s ? rRv : lRv) !== 1'b1 && n++ < 199);
		q = s ? rD : lD;
		b = s ? rRb : lRb;
		if (n >= 199) errors++;
	endtask
	// left writes 11, right writes 22 or reads, then left reads back
	task automatic race(input int lagL, lagR, input bit wrR, input logic [10:0] ra,
		input logic [1:0] expB);
		logic [7:0] q, lq, rq;
		logic lb, rb;
		fork
			begin repeat (lagL) @(posedge clk); acc(0, 1, 11'h123, 8'h11, lq, lb); end
			begin repeat (lagR) @(posedge clk); acc(1, wrR, ra, 8'h22, rq, rb); end
		join
		chk({6'h0, lb, rb}, {6'h0, expB});
		acc(0, 0, ra, 8'h00, q, lb);
		chk(q, expB[1] ? 8'h11 : 8'h22);
	endtask
	task automatic test_pass();
		logic [7:0] q;
		logic b;
		@(negedge clk);
		chk({lPins.ceB, lPins.rwB, lPins.oeB, lPins.dOe, 4'h0}, 8'he0);
		chk({4'h0, lRdy, rRdy, lBso, rBso}, 8'h0c);
		acc(0, 1, 11'h7ff, 8'ha5, q, b);
		chk({7'h0, b}, 8'h00);
		acc(1, 0, 11'h7ff, 8'h00, q, b);
		chk(q, 8'ha5);
		acc(1, 1, 11'h000, 8'h3c, q, b);
		acc(0, 0, 11'h000, 8'h00, q, b);
		chk(q, 8'h3c);
		$display("test_pass done");
	endtask
	task automatic test_tie();
		race(0, 0, 1'b1, 11'h123, 2'h1);
		race(0, 0, 1'b1, 11'h124, 2'h0);
		$display("test_tie done");
	endtask
	task automatic test_order();
		race(1, 0, 1'b0, 11'h123, 2'h2);
		$display("test_order done");
	endtask
	task automatic test_slave();
		@(posedge clk);
		slaveMode <= 1'b1;
		race(0, 0, 1'b1, 11'h123, 2'h1);
		race(1, 0, 1'b0, 11'h123, 2'h2);
		@(posedge clk);
		slaveMode <= 1'b0;
		$display("test_slave done");
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		test_pass();
		test_tie();
		test_order();
		test_slave();
		wrap_up();
	end
	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		#100us;
		errors++;
		wrap_up();
	end
endmodule
`default_nettype wire
